// >>> verilog/csm_pkg.sv
// package for the conversion source and mode control block
// assumes one 100 MHz clock and a register port fed by the serial interface logic
package csm_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CSM_REG_OFFSET = 8'h18; // source and mode register
  localparam logic [7:0] CSM_REG_RESET = 8'h00;
  localparam int CSM_DIAG_MSB = 7;
  localparam int CSM_DIAG_LSB = 4;
  localparam int CSM_INSEL_BIT = 3;
  localparam int CSM_MODE_MSB = 2;
  localparam int CSM_MODE_LSB = 0;

  // ----------------------------------------------------------------
  // field encodings
  // ----------------------------------------------------------------
  localparam logic [3:0] CSM_DIAG_TEMP = 4'h0;
  localparam logic [3:0] CSM_DIAG_ZERO = 4'h8;
  localparam logic [3:0] CSM_DIAG_POS_FS = 4'h9;
  localparam logic [3:0] CSM_DIAG_NEG_FS = 4'ha;
  localparam logic [2:0] CSM_MODE_CONT = 3'h0;
  localparam logic [2:0] CSM_MODE_ONESHOT = 3'h1;
  localparam logic [2:0] CSM_MODE_SINGLE = 3'h2;
  localparam logic [2:0] CSM_MODE_PERIODIC = 3'h3;

  // ----------------------------------------------------------------
  // timing counts, in clock cycles
  // ----------------------------------------------------------------
  localparam int CSM_CNT_W = 16;
  localparam int CSM_SETTLE_CYCLES = 64; // filter settling time
  localparam int CSM_STARTUP_CYCLES = 16; // leaving standby

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CSM_ST_STANDBY,
    CSM_ST_STARTUP,
    CSM_ST_CONVERT,
    CSM_ST_WAIT_SYNC,
    CSM_ST_IDLE_PERIOD
  } csm_state_t;

  // analog routing selects driven to the front end
  typedef struct packed {
    logic conversion_input_sel; // 0 analog pair, 1 diagnostic mux
    logic diag_temp;
    logic diag_zero;
    logic diag_pos_fs;
    logic diag_neg_fs;
    logic diag_reserved;
  } csm_route_t;

endpackage : csm_pkg

// >>> verilog/csm_conv_ctrl.sv
// conversion source and mode control: register, routing and sequencer
// assumes rst is synchronous to clk; sync_in comes straight from a pin
//
// Contract
// - diagnostic field 0 temp, 1000 zero check, 1001 +full scale, 1010 -full scale
// - bit 3 zero routes analog pair, one routes diagnostic mux
// - mode 000 converts continuously, ready pulses every completed conversion
// - mode 001 modulator runs, each sync rising edge starts a conversion; edges that arrive while a conversion runs are ignored
// - mode 001 toggles ready when the triggered conversion completes
// - mode 010 does one conversion, one result, then enters standby
// - single conversion from standby first spends a start-up interval
// - mode 011 leaves standby, converts, returns, with no host request
// - periodic standby to converting ratio comes from a separate register
// - register at 0x18 resets to 0x00: continuous, analog pair, temp
`timescale 1ns/1ps

module csm_conv_ctrl #(
  parameter int SETTLE_CYCLES = csm_pkg::CSM_SETTLE_CYCLES,
  parameter int STARTUP_CYCLES = csm_pkg::CSM_STARTUP_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic sync_in,
  input wire logic [7:0] standby_ratio,
  output csm_pkg::csm_route_t route,
  output logic modulator_run,
  output logic standby,
  output logic result_ready_out
);

  // ----------------------------------------------------------------
  // local types and constants
  // ----------------------------------------------------------------
  localparam int CW = csm_pkg::CSM_CNT_W;
  localparam logic [CW-1:0] SETTLE_LAST = CW'(SETTLE_CYCLES - 1);
  localparam logic [CW-1:0] STARTUP_LAST = CW'(STARTUP_CYCLES - 1);

  logic [7:0] conv_reg;
  logic [3:0] diagnostic_source_sel;
  logic conversion_input_sel;
  logic [2:0] conversion_mode_field;
  logic reg_hit_wr;
  logic sync_meta;
  logic sync_q;
  logic sync_prev;
  logic sync_rise;
  csm_pkg::csm_state_t state;
  csm_pkg::csm_state_t next_state;
  logic [CW-1:0] cnt;
  logic [7:0] period_cnt;
  logic conv_done;
  logic startup_done;
  logic period_tick;
  logic idle_done;

  assign diagnostic_source_sel = conv_reg[csm_pkg::CSM_DIAG_MSB:csm_pkg::CSM_DIAG_LSB];
  assign conversion_input_sel = conv_reg[csm_pkg::CSM_INSEL_BIT];
  assign conversion_mode_field = conv_reg[csm_pkg::CSM_MODE_MSB:csm_pkg::CSM_MODE_LSB];
  assign reg_hit_wr = reg_wr && (reg_addr == csm_pkg::CSM_REG_OFFSET);

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  // reset value
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      conv_reg <= csm_pkg::CSM_REG_RESET;
    end
    else if (reg_hit_wr)
    begin
      conv_reg <= reg_wdata;
    end
  end

  // read data, unmapped offsets read zero
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      reg_rdata <= 8'h00;
    end
    else if (reg_rd)
    begin
      reg_rdata <= (reg_addr == csm_pkg::CSM_REG_OFFSET) ? conv_reg : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // analog routing
  // ----------------------------------------------------------------
  // diagnostic decode
  // reserved codes flagged, no source on
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      route <= '0;
    end
    else
    begin
      route.conversion_input_sel <= conversion_input_sel;
      route.diag_temp <= (diagnostic_source_sel == csm_pkg::CSM_DIAG_TEMP);
      route.diag_zero <= (diagnostic_source_sel == csm_pkg::CSM_DIAG_ZERO);
      route.diag_pos_fs <= (diagnostic_source_sel == csm_pkg::CSM_DIAG_POS_FS);
      route.diag_neg_fs <= (diagnostic_source_sel == csm_pkg::CSM_DIAG_NEG_FS);
      route.diag_reserved <= !((diagnostic_source_sel == csm_pkg::CSM_DIAG_TEMP)
        || (diagnostic_source_sel == csm_pkg::CSM_DIAG_ZERO)
        || (diagnostic_source_sel == csm_pkg::CSM_DIAG_POS_FS)
        || (diagnostic_source_sel == csm_pkg::CSM_DIAG_NEG_FS));
    end
  end

  // ----------------------------------------------------------------
  // sync input synchroniser and edge detect
  // ----------------------------------------------------------------
  // two stages, then one more for the edge
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync_meta <= 1'b0;
      sync_q <= 1'b0;
      sync_prev <= 1'b0;
    end
    else
    begin
      sync_meta <= sync_in;
      sync_q <= sync_meta;
      sync_prev <= sync_q;
    end
  end

  assign sync_rise = sync_q && !sync_prev;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  assign conv_done = (state == csm_pkg::CSM_ST_CONVERT) && (cnt == SETTLE_LAST);
  assign startup_done = (state == csm_pkg::CSM_ST_STARTUP) && (cnt == STARTUP_LAST);
  assign period_tick = (state == csm_pkg::CSM_ST_IDLE_PERIOD) && (cnt == SETTLE_LAST);
  assign idle_done = (state == csm_pkg::CSM_ST_IDLE_PERIOD)
    && ((standby_ratio == 8'h00) || (period_tick && (period_cnt == standby_ratio - 8'h01)));

  // next state; a register write restarts the selected mode
  always_comb
  begin
    next_state = state;
    if (reg_hit_wr)
    begin
      case (reg_wdata[csm_pkg::CSM_MODE_MSB:csm_pkg::CSM_MODE_LSB])
        csm_pkg::CSM_MODE_CONT: next_state = csm_pkg::CSM_ST_CONVERT;
        csm_pkg::CSM_MODE_ONESHOT: next_state = csm_pkg::CSM_ST_WAIT_SYNC;
        csm_pkg::CSM_MODE_SINGLE: next_state = (state == csm_pkg::CSM_ST_STANDBY)
          ? csm_pkg::CSM_ST_STARTUP : csm_pkg::CSM_ST_CONVERT;
        csm_pkg::CSM_MODE_PERIODIC: next_state = csm_pkg::CSM_ST_CONVERT;
        default: next_state = csm_pkg::CSM_ST_STANDBY;
      endcase
    end
    else
    begin
      case (state)
        csm_pkg::CSM_ST_WAIT_SYNC: if (sync_rise) next_state = csm_pkg::CSM_ST_CONVERT;
        csm_pkg::CSM_ST_STARTUP: if (startup_done) next_state = csm_pkg::CSM_ST_CONVERT;
        csm_pkg::CSM_ST_CONVERT:
        begin
          if (conv_done)
          begin
            case (conversion_mode_field)
              csm_pkg::CSM_MODE_CONT: next_state = csm_pkg::CSM_ST_CONVERT;
              csm_pkg::CSM_MODE_ONESHOT: next_state = csm_pkg::CSM_ST_WAIT_SYNC;
              csm_pkg::CSM_MODE_SINGLE: next_state = csm_pkg::CSM_ST_STANDBY;
              csm_pkg::CSM_MODE_PERIODIC: next_state = csm_pkg::CSM_ST_IDLE_PERIOD;
              default: next_state = csm_pkg::CSM_ST_STANDBY;
            endcase
          end
        end
        csm_pkg::CSM_ST_IDLE_PERIOD:
        begin
          if (idle_done)
          begin
            next_state = csm_pkg::CSM_ST_STARTUP;
          end
        end
        default: next_state = state;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= csm_pkg::CSM_ST_CONVERT;
    end
    else
    begin
      state <= next_state;
    end
  end

  // interval counter, restarts on every state entry
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt <= '0;
    end
    else if ((next_state != state) || conv_done || period_tick || reg_hit_wr)
    begin
      cnt <= '0;
    end
    else
    begin
      cnt <= cnt + CW'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst || (state != csm_pkg::CSM_ST_IDLE_PERIOD))
    begin
      period_cnt <= 8'h00;
    end
    else if (period_tick)
    begin
      period_cnt <= period_cnt + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // status outputs
  // ----------------------------------------------------------------
  // modulator off in standby, start-up and idle
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      modulator_run <= 1'b1;
      standby <= 1'b0;
    end
    else
    begin
      standby <= (next_state == csm_pkg::CSM_ST_STANDBY)
        || (next_state == csm_pkg::CSM_ST_IDLE_PERIOD);
      modulator_run <= (next_state == csm_pkg::CSM_ST_CONVERT)
        || (next_state == csm_pkg::CSM_ST_WAIT_SYNC);
    end
  end

  // ready: toggle in one-shot, one-cycle pulse otherwise
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      result_ready_out <= 1'b0;
    end
    else if (conv_done && !reg_hit_wr
      && (conversion_mode_field == csm_pkg::CSM_MODE_ONESHOT))
    begin
      result_ready_out <= !result_ready_out;
    end
    else if (conversion_mode_field != csm_pkg::CSM_MODE_ONESHOT)
    begin
      result_ready_out <= conv_done && !reg_hit_wr;
    end
  end

endmodule : csm_conv_ctrl

// >>> bench/csm_conv_ctrl_assertions.sv
// checker for the source and mode control block
// sees only the top ports; bound at the foot of this file
`timescale 1ns/1ps

module csm_conv_ctrl_assertions #(
  parameter int SETTLE_CYCLES = 4,
  parameter int STARTUP_CYCLES = 2
) (
  input logic clk,
  input logic rst,
  input logic [7:0] reg_addr,
  input logic reg_wr,
  input logic reg_rd,
  input logic [7:0] reg_wdata,
  input logic [7:0] reg_rdata,
  input logic sync_in,
  input logic [7:0] standby_ratio,
  input csm_pkg::csm_route_t route,
  input logic modulator_run,
  input logic standby,
  input logic result_ready_out
);
  localparam int LO = SETTLE_CYCLES;
  localparam int HI = SETTLE_CYCLES + 2;
  localparam int PLO = SETTLE_CYCLES + STARTUP_CYCLES - 1;
  localparam int PHI = SETTLE_CYCLES + STARTUP_CYCLES + 3;
  logic [7:0] shadow;
  logic [2:0] quiet;
  logic [4:0] exp_diag;
  // ------
  // register shadow
  // ------
  // copy of the register and cycles since a write
  always_ff @(posedge clk)
  begin
    if (rst)
      shadow <= 8'h00;
    else if (reg_wr && reg_addr == csm_pkg::CSM_REG_OFFSET)
      shadow <= reg_wdata;
  end
  always_ff @(posedge clk)
  begin
    if (rst || reg_wr)
      quiet <= 3'h0;
    else if (quiet != 3'h7)
      quiet <= quiet + 3'h1;
  end
  // one-hot diagnostic select, reserved when none
  assign exp_diag[4:1] = {shadow[7:4] == 4'h0, shadow[7:4] == 4'h8,
                          shadow[7:4] == 4'h9, shadow[7:4] == 4'ha};
  assign exp_diag[0] = exp_diag[4:1] == 4'h0;
  // ------
  // properties
  // ------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_sleep;
    ##[1:3] (standby && !modulator_run);
  endsequence
  sequence s_late_wr;
    ##[0:3] reg_wr;
  endsequence
  property p_insel;
    quiet > 3'h2 |-> route.conversion_input_sel == shadow[3];
  endproperty
  a_insel: assert property (p_insel) else $error("input select wrong");
  property p_diag;
    quiet > 3'h2 |-> route[4:0] == exp_diag;
  endproperty
  a_diag: assert property (p_diag) else $error("diag select wrong");
  property p_rd_back;
    reg_rd && reg_addr == 8'h18 && !reg_wr |=> reg_rdata == shadow;
  endproperty
  a_rd_back: assert property (p_rd_back) else $error("readback wrong");
  property p_rd_unmap;
    reg_rd && reg_addr != 8'h18 |=> reg_rdata == 8'h00;
  endproperty
  a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read");
  property p_run;
    quiet > 3'h2 && shadow[2:1] == 2'b00 |-> modulator_run && !standby;
  endproperty
  a_run: assert property (p_run) else $error("modulator stopped");
  property p_pulse;
    $rose(result_ready_out) && shadow[2:0] != 3'h1 |=> !result_ready_out;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ready not a pulse");
  property p_period;
    $rose(result_ready_out) && shadow[2:0] == 3'h0
      |-> ##[LO:HI] result_ready_out or ##[1:HI] reg_wr;
  endproperty
  a_period: assert property (p_period) else $error("ready period");
  property p_single;
    $rose(result_ready_out) && shadow[2:0] == 3'h2 |-> s_sleep or s_late_wr;
  endproperty
  a_single: assert property (p_single) else $error("no standby");
  property p_periodic;
    $fell(standby) && shadow[2:0] == 3'h3 && quiet > 3'h2
      |-> ##[PLO:PHI] result_ready_out or ##[1:PHI] reg_wr;
  endproperty
  a_periodic: assert property (p_periodic) else $error("periodic late");
  property p_reserved;
    quiet > 3'h3 && shadow[2] |-> standby && !modulator_run && !result_ready_out;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved mode");
endmodule : csm_conv_ctrl_assertions

bind csm_conv_ctrl csm_conv_ctrl_assertions #(
  .SETTLE_CYCLES(SETTLE_CYCLES), .STARTUP_CYCLES(STARTUP_CYCLES)
) chk_u (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sync_in(sync_in),
  .standby_ratio(standby_ratio), .route(route), .modulator_run(modulator_run),
  .standby(standby), .result_ready_out(result_ready_out)
);

// >>> bench/csm_host_sync.sv
// host model driving the sync pin
// assumes fire is a one-cycle request from the bench
`timescale 1ns/1ps

module csm_host_sync (
  input logic clk,
  input logic rst,
  input logic fire,
  output logic sync_in
);
  logic [2:0] hold;
  // single shots at low power
  // host runs diagnostics and single shots at low power
  // rising edge held four cycles, then driven low
  always_ff @(posedge clk)
  begin
    if (rst)
      hold <= 3'h0;
    else if (fire)
      hold <= 3'h4;
    else if (hold != 3'h0)
      hold <= hold - 3'h1;
  end
  assign sync_in = hold != 3'h0;
endmodule : csm_host_sync

// >>> bench/csm_conv_ctrl_tb_top.sv
// testbench for the source and mode control block
// assumes short settle and start-up counts set below
`timescale 1ns/1ps

module csm_conv_ctrl_tb_top;
  localparam int ST = 4;
  localparam int SU = 2;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [7:0] standby_ratio = 8'h00;
  logic sync_in;
  logic fire = 1'b0;
  csm_pkg::csm_route_t route;
  logic modulator_run;
  logic standby;
  logic rdy;
  int error_cnt = 0;
  int compares = 0;
  int n;
  int m;
  logic [7:0] d;

  csm_conv_ctrl #(.SETTLE_CYCLES(ST), .STARTUP_CYCLES(SU)) dut_u (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sync_in(sync_in),
    .standby_ratio(standby_ratio), .route(route), .modulator_run(modulator_run),
    .standby(standby), .result_ready_out(rdy));
  csm_host_sync host_u (.clk(clk), .rst(rst), .fire(fire), .sync_in(sync_in));

  initial forever #5 clk = ~clk;

  // ------
  // shared tasks
  // ------
  task automatic summarize();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic step(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : step
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    step(1);
    v = reg_rdata;
  endtask : rd
  // cycles until the ready output changes, bounded
  task automatic wait_chg(output int k);
    logic r0;
    #1 r0 = rdy;
    k = 0;
    while (rdy === r0)
    begin
      step(1);
      k++;
      if (k > 40)
      begin
        error_cnt++;
        $display("BAD ready wait expected 40 seen %0d", k);
        summarize();
      end
    end
  endtask : wait_chg
  task automatic pulse_sync();
    @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
  endtask : pulse_sync

  // ------
  // scenarios
  // ------
  task automatic t_reset();
    rd(8'h18, d);
    chk("reg reset", csm_pkg::CSM_REG_RESET, d);
    chk("route reset", 8'h10, {2'b00, route});
    chk("run reset", 8'h01, {7'h00, modulator_run});
  endtask : t_reset
  task automatic t_route();
    logic [3:0] c [5] = '{4'h0, 4'h8, 4'h9, 4'ha, 4'hb};
    logic [5:0] e [5] = '{6'h30, 6'h28, 6'h24, 6'h22, 6'h21};
    for (int i = 0; i < 5; i++)
    begin
      wr(8'h18, {c[i], 4'h8});
      rd(8'h18, d);
      chk("readback", {c[i], 4'h8}, d);
      chk("route", {2'b00, e[i]}, {2'b00, route});
    end
    wr(8'h18, 8'h90);
    wr(8'h17, 8'hff);
    rd(8'h18, d);
    chk("after stray", 8'h90, d);
    chk("route pair", 8'h04, {2'b00, route});
    rd(8'h17, d);
    chk("unmapped", 8'h00, d);
  endtask : t_route
  task automatic t_cont();
    wr(8'h18, 8'h00);
    wait_chg(n);
    step(1);
    wait_chg(n);
    chk("cont gap", 8'h01, {7'h00, n >= ST - 1 && n <= ST});
  endtask : t_cont
  task automatic t_oneshot();
    wr(8'h18, 8'h01);
    step(3 * ST);
    chk("no sync idle", 8'h00, {7'h00, rdy});
    pulse_sync();
    wait_chg(n);
    chk("sync latency", 8'h01, {7'h00, n > ST});
    step(3 * ST);
    chk("toggle holds", 8'h01, {7'h00, rdy});
    pulse_sync();
    wait_chg(n);
    chk("toggle back", 8'h00, {7'h00, rdy});
  endtask : t_oneshot
  task automatic t_single();
    wr(8'h18, 8'h02);
    wait_chg(n);
    step(3);
    chk("single standby", 8'h01, {7'h00, standby});
    m = 0;
    repeat (5 * ST)
    begin
      step(1);
      m += int'(rdy);
    end
    chk("extra result", 8'h00, m[7:0]);
    wr(8'h18, 8'h02);
    wait_chg(m);
    chk("start-up time", 8'h01, {7'h00, m >= n + SU});
  endtask : t_single
  task automatic t_periodic();
    @(posedge clk);
    standby_ratio <= 8'h02;
    wr(8'h18, 8'h03);
    wait_chg(n);
    step(3);
    chk("idle standby", 8'h01, {7'h00, standby && !modulator_run});
    wait_chg(n);
    chk("idle ratio", 8'h01, {7'h00, n >= 3 * ST + SU - 3 && n <= 3 * ST + SU});
  endtask : t_periodic
  task automatic t_reserved();
    for (int i = 4; i < 8; i++)
    begin
      wr(8'h18, 8'(i));
      step(5);
      chk("reserved mode", 8'h01, {7'h00, standby && !modulator_run});
    end
    wr(8'h18, 8'h00);
  endtask : t_reserved

  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_route();
    t_cont();
    t_oneshot();
    t_single();
    t_periodic();
    t_reserved();
    summarize();
  end
endmodule : csm_conv_ctrl_tb_top
